// ==== pbsi_pkg.sv ====
// constants and types for the pipelined burst sram interface
// Overview of operation
// RULE1: output enable low drives data pins
// RULE2: first read cycle after deselect stays tristated
// RULE3: sampled low advance steps burst address
// RULE4: processor strobe captures address and burst bits
// RULE5: controller strobe captures address and burst bits
// RULE6: processor strobe wins when both asserted
// RULE7: processor strobe ignored while first select high
// RULE8: sleep input idles device, contents kept
// RULE9: outputs show data addressed previous edge
// RULE10: input data captured on rising edge
// RULE11: strap low linear, high interleaved, kept static
// RULE12: scan output changes on test clock fall
// RULE13: scan input and mode sampled on rise
// RULE14: all inputs and outputs registered on rise; output_enable_n reaches dq_oe_n without a register here
// RULE15: two-bit counter wraps within group four
// RULE16: global write writes all four lanes
// RULE17: byte write needs lane select and enable
// RULE18: read starts on strobe, selected, writes high
// RULE19: read data reaches bus next edge
// RULE20: back-to-back single reads supported
// RULE21: deselect tristates outputs immediately
// RULE22: chip selects evaluated only on address load
// RULE23: master drives byte enable with lane selects
// RULE24: interleave xors count, linear adds modulo four
package pbsi_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int BURST_W = 2;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [LANES-1:0] LANES_ALL = 4'hF;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [LANES-1:0] PAR_RST = 4'h0;
   localparam logic [2:0] SCAN_RESET_ONES = 3'h5;
   localparam logic [2:0] SCAN_CNT_RST = 3'h0;
   typedef enum logic [1:0] {
      ST_DESEL = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } pbsi_state_t;
endpackage

// ==== pbsi_burst_ctr.sv ====
// two-bit wraparound burst counter with selectable order
`timescale 1ns/10ps
module pbsi_burst_ctr (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [pbsi_pkg::BURST_W-1:0] start_bits,
   input wire logic advance,
   input wire logic interleave,
   output logic [pbsi_pkg::BURST_W-1:0] burst_bits
);
   import pbsi_pkg::*;

   logic [BURST_W-1:0] start_reg;
   logic [BURST_W-1:0] count_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         start_reg <= BURST_RST;
         count_reg <= BURST_RST;
      end else if (load) begin
         start_reg <= start_bits; // RULE15
         count_reg <= BURST_RST;
      end else if (advance) begin
         // two bits wrap by themselves
         count_reg <= count_reg + BURST_STEP; // RULE15
      end
   end

   always_comb begin
      if (interleave) begin
         burst_bits = start_reg ^ count_reg; // RULE24
      end else begin
         burst_bits = start_reg + count_reg; // RULE24
      end
   end
endmodule

// ==== pbsi_sram_if.sv ====
// synchronous control, data and scan logic of the burst sram
`timescale 1ns/10ps
module pbsi_sram_if (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [pbsi_pkg::ADDR_W-1:0] addr,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic all_bytes_write_n,
   input wire logic byte_write_enable_n,
   input wire logic [pbsi_pkg::LANES-1:0] byte_lane_select_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order_strap,
   input wire logic [pbsi_pkg::DATA_W-1:0] dq_in,
   output logic [pbsi_pkg::DATA_W-1:0] dq_out,
   input wire logic [pbsi_pkg::LANES-1:0] parity_lines_in,
   output logic [pbsi_pkg::LANES-1:0] parity_lines_out,
   output logic dq_oe_n,
   output logic [pbsi_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic [pbsi_pkg::DATA_W-1:0] mem_rd_data,
   input wire logic [pbsi_pkg::LANES-1:0] mem_rd_parity,
   output logic mem_wr_en,
   output logic [pbsi_pkg::LANES-1:0] mem_byte_we,
   output logic [pbsi_pkg::ADDR_W-1:0] mem_wr_addr,
   output logic [pbsi_pkg::DATA_W-1:0] mem_wr_data,
   output logic [pbsi_pkg::LANES-1:0] mem_wr_parity,
   output logic sleeping,
   input wire logic test_clk,
   input wire logic test_data_in,
   input wire logic test_mode_select,
   output logic test_data_out
);
   import pbsi_pkg::*;

   pbsi_state_t state_reg;
   pbsi_state_t state_next;
   logic [ADDR_W-1:0] addr_reg;
   logic [BURST_W-1:0] burst_bits;
   logic sleep_s1_reg;
   logic sleep_s2_reg;
   logic strap_s1_reg;
   logic strap_s2_reg;
   logic proc_load;
   logic any_load;
   logic sel_pins;
   logic selected;
   logic advance;
   logic wr_req;
   logic write_now;
   logic read_now;
   logic desel_now;
   logic [LANES-1:0] lanes_next;
   logic [ADDR_W-1:0] cur_addr;
   logic rd_pend_reg;
   logic out_valid_reg;
   logic mask_reg;
   logic [DATA_W-1:0] dq_out_reg;
   logic [LANES-1:0] par_out_reg;
   logic mem_wr_en_reg;
   logic [LANES-1:0] mem_byte_we_reg;
   logic [ADDR_W-1:0] mem_wr_addr_reg;
   logic [DATA_W-1:0] mem_wr_data_reg;
   logic [LANES-1:0] mem_wr_par_reg;
   logic tck_s1_reg;
   logic tck_s2_reg;
   logic tck_s3_reg;
   logic tdi_s1_reg;
   logic tdi_s2_reg;
   logic tms_s1_reg;
   logic tms_s2_reg;
   logic tck_rise;
   logic tck_fall;
   logic bypass_reg;
   logic [2:0] tms_cnt_reg;
   logic tdo_reg;

   // sleep and strap pins pass two flops before use
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
         strap_s1_reg <= 1'b1;
         strap_s2_reg <= 1'b1;
      end else begin
         sleep_s1_reg <= sleep_request; // RULE8
         sleep_s2_reg <= sleep_s1_reg;
         strap_s1_reg <= burst_order_strap; // RULE11
         strap_s2_reg <= strap_s1_reg;
      end
   end

   assign selected = (state_reg != ST_DESEL);
   // strobes are blocked in sleep; pending access is dropped
   assign proc_load = !proc_addr_strobe_n && !chip_select_first_n
      && !sleep_s2_reg; // RULE7
   assign any_load = proc_load
      || (!ctrl_addr_strobe_n && !sleep_s2_reg); // RULE6 RULE5
   // chip selects only matter on a load edge
   assign sel_pins = !chip_select_first_n && chip_select_second
      && !chip_select_third_n; // RULE22
   assign advance = !any_load && selected && !burst_advance_n
      && !sleep_s2_reg; // RULE3
   assign wr_req = !all_bytes_write_n
      || (!byte_write_enable_n && (byte_lane_select_n != LANES_ALL));

   always_comb begin
      if (!all_bytes_write_n) begin
         lanes_next = LANES_ALL; // RULE16
      end else if (!byte_write_enable_n) begin
         lanes_next = ~byte_lane_select_n; // RULE17
      end else begin
         lanes_next = LANES_NONE;
      end
   end

   always_comb begin
      write_now = 1'b0;
      read_now = 1'b0;
      desel_now = 1'b0;
      if (sleep_s2_reg) begin
         desel_now = 1'b1;
      end else if (any_load) begin
         if (!sel_pins) begin
            desel_now = 1'b1; // RULE21
         end else if (proc_load) begin
            // write controls ignored on the strobe edge
            read_now = 1'b1; // RULE4
         end else if (wr_req) begin
            write_now = 1'b1;
         end else begin
            read_now = all_bytes_write_n
               && byte_write_enable_n; // RULE18
         end
      end else if (selected) begin
         write_now = wr_req;
         read_now = !wr_req;
      end
   end

   always_comb begin
      case ({desel_now, write_now, read_now})
         3'b010: state_next = ST_WRITE;
         3'b001: state_next = ST_READ;
         3'b000: state_next = (any_load || sleep_s2_reg) ? ST_DESEL
            : state_reg;
         default: state_next = ST_DESEL;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= ST_DESEL;
      end else begin
         state_reg <= state_next;
      end
   end

   // address register; chip selects are not stored
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_reg <= ADDR_RST;
      end else if (any_load) begin
         addr_reg <= addr; // RULE4 RULE5 RULE14
      end
   end

   pbsi_burst_ctr u_burst (
      .core_clk(core_clk),
      .rst(rst),
      .load(any_load),
      .start_bits(addr[BURST_W-1:0]),
      .advance(advance),
      .interleave(strap_s2_reg),
      .burst_bits(burst_bits)
   );

   assign mem_rd_addr = {addr_reg[ADDR_W-1:BURST_W], burst_bits};
   // a write on the strobe edge uses the pin address directly
   assign cur_addr = any_load ? addr : mem_rd_addr;

   // self-timed write: one pulse after data is captured
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mem_wr_en_reg <= 1'b0;
         mem_byte_we_reg <= LANES_NONE;
         mem_wr_addr_reg <= ADDR_RST;
         mem_wr_data_reg <= DATA_RST;
         mem_wr_par_reg <= PAR_RST;
      end else begin
         mem_wr_en_reg <= write_now;
         if (write_now) begin
            mem_byte_we_reg <= lanes_next; // RULE16 RULE17
            mem_wr_addr_reg <= cur_addr;
            mem_wr_data_reg <= dq_in; // RULE10
            mem_wr_par_reg <= parity_lines_in; // RULE10
         end
      end
   end

   // one cycle of output pipelining
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_pend_reg <= 1'b0;
         out_valid_reg <= 1'b0;
         mask_reg <= 1'b0;
         dq_out_reg <= DATA_RST;
         par_out_reg <= PAR_RST;
      end else begin
         rd_pend_reg <= read_now; // RULE20
         out_valid_reg <= rd_pend_reg && !write_now
            && !desel_now; // RULE19 RULE21
         mask_reg <= read_now && !selected; // RULE2
         if (rd_pend_reg) begin
            dq_out_reg <= mem_rd_data; // RULE9 RULE14
            par_out_reg <= mem_rd_parity; // RULE9
         end
      end
   end

   // enable is asynchronous by design, so it gates the drivers
   // directly rather than through the clocked path
   assign dq_oe_n = output_enable_n || !out_valid_reg || mask_reg
      || sleep_s2_reg; // RULE1 RULE2 RULE8
   assign dq_out = dq_out_reg;
   assign parity_lines_out = par_out_reg;
   assign mem_wr_en = mem_wr_en_reg;
   assign mem_byte_we = mem_byte_we_reg;
   assign mem_wr_addr = mem_wr_addr_reg;
   assign mem_wr_data = mem_wr_data_reg;
   assign mem_wr_parity = mem_wr_par_reg;
   assign sleeping = sleep_s2_reg;

   // scan port: test clock is oversampled, so it must run
   // well below a quarter of the core clock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tck_s1_reg <= 1'b0;
         tck_s2_reg <= 1'b0;
         tck_s3_reg <= 1'b0;
         tdi_s1_reg <= 1'b1;
         tdi_s2_reg <= 1'b1;
         tms_s1_reg <= 1'b1;
         tms_s2_reg <= 1'b1;
      end else begin
         tck_s1_reg <= test_clk;
         tck_s2_reg <= tck_s1_reg;
         tck_s3_reg <= tck_s2_reg;
         tdi_s1_reg <= test_data_in;
         tdi_s2_reg <= tdi_s1_reg;
         tms_s1_reg <= test_mode_select;
         tms_s2_reg <= tms_s1_reg;
      end
   end

   assign tck_rise = tck_s2_reg && !tck_s3_reg;
   assign tck_fall = !tck_s2_reg && tck_s3_reg;

   // bypass stage only; five high mode samples clear it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bypass_reg <= 1'b0;
         tms_cnt_reg <= SCAN_CNT_RST;
      end else if (tck_rise) begin
         if (!tms_s2_reg) begin
            tms_cnt_reg <= SCAN_CNT_RST; // RULE13
            bypass_reg <= tdi_s2_reg; // RULE13
         end else if (tms_cnt_reg == SCAN_RESET_ONES - 3'h1) begin
            tms_cnt_reg <= SCAN_RESET_ONES;
            bypass_reg <= 1'b0;
         end else if (tms_cnt_reg != SCAN_RESET_ONES) begin
            tms_cnt_reg <= tms_cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tdo_reg <= 1'b0;
      end else if (tck_fall) begin
         tdo_reg <= bypass_reg; // RULE12
      end
   end

   assign test_data_out = tdo_reg;

   property p_oe_high_tristates;
      @(posedge core_clk) disable iff (rst)
      output_enable_n |-> dq_oe_n;
   endproperty
   a_oe_high_tristates: assert property (p_oe_high_tristates) // RULE1
      else $error("pins driven with output enable high");

   property p_first_masked;
      @(posedge core_clk) disable iff (rst)
      (read_now && !selected) |=> dq_oe_n;
   endproperty
   a_first_masked: assert property (p_first_masked) // RULE2
      else $error("pins driven in first cycle after deselect");

   property p_advance_linear;
      @(posedge core_clk) disable iff (rst)
      (advance && !strap_s2_reg) |=>
         burst_bits == $past(burst_bits) + BURST_STEP;
   endproperty
   a_advance_linear: assert property (p_advance_linear) // RULE3
      else $error("linear burst did not step");

   property p_advance_interleave;
      @(posedge core_clk) disable iff (rst)
      (any_load && strap_s2_reg) ##1 advance |=>
         burst_bits == ($past(burst_bits) ^ 2'h1);
   endproperty
   a_advance_interleave: assert property (p_advance_interleave) // RULE24
      else $error("interleaved second address wrong");

   property p_proc_load;
      @(posedge core_clk) disable iff (rst)
      proc_load |=> (addr_reg == $past(addr))
         && (burst_bits == $past(addr[BURST_W-1:0]));
   endproperty
   a_proc_load: assert property (p_proc_load) // RULE4
      else $error("processor strobe did not load address");

   property p_ctrl_load;
      @(posedge core_clk) disable iff (rst)
      (!ctrl_addr_strobe_n && !sleep_s2_reg) |=>
         mem_rd_addr == $past(addr);
   endproperty
   a_ctrl_load: assert property (p_ctrl_load) // RULE5
      else $error("controller strobe did not load address");

   property p_proc_wins;
      @(posedge core_clk) disable iff (rst)
      proc_load |=> !mem_wr_en;
   endproperty
   a_proc_wins: assert property (p_proc_wins) // RULE6
      else $error("write taken on processor strobe edge");

   property p_proc_ignored;
      @(posedge core_clk) disable iff (rst)
      // state may still move on a write request, so only loads count
      (chip_select_first_n && ctrl_addr_strobe_n) |->
         !any_load ##1 $stable(addr_reg);
   endproperty
   a_proc_ignored: assert property (p_proc_ignored) // RULE7
      else $error("processor strobe acted with first select high");

   property p_sleep_idle;
      @(posedge core_clk) disable iff (rst)
      sleep_s2_reg |=> dq_oe_n && !mem_wr_en && state_reg == ST_DESEL;
   endproperty
   a_sleep_idle: assert property (p_sleep_idle) // RULE8
      else $error("activity during sleep");

   property p_pipeline;
      @(posedge core_clk) disable iff (rst)
      rd_pend_reg |=> dq_out == $past(mem_rd_data);
   endproperty
   a_pipeline: assert property (p_pipeline) // RULE9
      else $error("output register missed read data");

   property p_data_capture;
      @(posedge core_clk) disable iff (rst)
      write_now |=> mem_wr_en && mem_wr_data == $past(dq_in)
         && mem_byte_we == $past(lanes_next);
   endproperty
   a_data_capture: assert property (p_data_capture) // RULE10
      else $error("write data not captured");

   property p_global_write;
      @(posedge core_clk) disable iff (rst)
      (write_now && !all_bytes_write_n) |=> mem_byte_we == LANES_ALL;
   endproperty
   a_global_write: assert property (p_global_write) // RULE16
      else $error("global write missed a lane");

   property p_desel;
      @(posedge core_clk) disable iff (rst)
      (any_load && !sel_pins) |=> dq_oe_n && !selected;
   endproperty
   a_desel: assert property (p_desel) // RULE21
      else $error("outputs driven after deselect");

   property p_tdo_on_fall;
      @(posedge core_clk) disable iff (rst)
      !tck_fall |=> $stable(test_data_out);
   endproperty
   a_tdo_on_fall: assert property (p_tdo_on_fall) // RULE12
      else $error("scan output moved off a falling edge");

   property p_read_visible;
      @(posedge core_clk) disable iff (rst)
      read_now ##1 (!write_now && !desel_now && !sleep_s2_reg)
         ##0 selected ##1 (!output_enable_n && !sleep_s2_reg)
         |-> !dq_oe_n;
   endproperty
   a_read_visible: assert property (p_read_visible) // RULE19
      else $error("read data not driven with enable low");

   c_back_to_back: cover property (@(posedge core_clk) disable iff (rst)
      read_now && any_load ##1 read_now && any_load);
   c_ctrl_write: cover property (@(posedge core_clk) disable iff (rst)
      write_now && any_load);
   c_burst_four: cover property (@(posedge core_clk) disable iff (rst)
      advance ##1 advance ##1 advance);
   c_sleep: cover property (@(posedge core_clk) disable iff (rst)
      sleep_s2_reg ##1 !sleep_s2_reg);
endmodule

// ==== pbsi_mem_model.sv ====
// array model behind the interface, with byte-lane writes
`timescale 1ns/10ps
module pbsi_mem_model (
   core_clk,
   mem_rd_addr,
   mem_rd_data,
   mem_rd_parity,
   mem_wr_en,
   mem_byte_we,
   mem_wr_addr,
   mem_wr_data,
   mem_wr_parity
);
   import pbsi_pkg::*;
   input wire logic core_clk;
   input wire logic [pbsi_pkg::ADDR_W-1:0] mem_rd_addr;
   output logic [pbsi_pkg::DATA_W-1:0] mem_rd_data;
   output logic [pbsi_pkg::LANES-1:0] mem_rd_parity;
   input wire logic mem_wr_en;
   input wire logic [pbsi_pkg::LANES-1:0] mem_byte_we;
   input wire logic [pbsi_pkg::ADDR_W-1:0] mem_wr_addr;
   input wire logic [pbsi_pkg::DATA_W-1:0] mem_wr_data;
   input wire logic [pbsi_pkg::LANES-1:0] mem_wr_parity;
   logic [DATA_W-1:0] word_reg [16];
   logic [LANES-1:0] par_reg [16];
   initial begin
      for (int i = 0; i < 16; i++) begin
         word_reg[i] = 32'hC3A50000 | i;
         par_reg[i] = i[3:0];
      end
   end
   // low four bits decode only; a small array keeps the run short
   assign mem_rd_data = word_reg[mem_rd_addr[3:0]];
   assign mem_rd_parity = par_reg[mem_rd_addr[3:0]];
   always @(posedge core_clk) begin
      for (int l = 0; l < LANES; l++) begin
         if (mem_wr_en && mem_byte_we[l]) begin
            word_reg[mem_wr_addr[3:0]][8*l +: 8] <= mem_wr_data[8*l +: 8];
            par_reg[mem_wr_addr[3:0]][l] <= mem_wr_parity[l];
         end
      end
   end
endmodule

// ==== pbsi_sram_if_bench.sv ====
// self-checking bench for the burst sram interface
`timescale 1ns/10ps
module pbsi_sram_if_bench;
   import pbsi_pkg::*;
   logic core_clk, rst, proc_addr_strobe_n, ctrl_addr_strobe_n;
   logic burst_advance_n, chip_select_first_n, chip_select_second;
   logic chip_select_third_n, all_bytes_write_n, byte_write_enable_n;
   logic output_enable_n, sleep_request, burst_order_strap;
   logic dq_oe_n, mem_wr_en, sleeping, test_data_out;
   logic test_clk, test_data_in, test_mode_select;
   logic [ADDR_W-1:0] addr, mem_rd_addr, mem_wr_addr;
   logic [LANES-1:0] byte_lane_select_n, parity_lines_in, parity_lines_out;
   logic [LANES-1:0] mem_rd_parity, mem_byte_we, mem_wr_parity;
   logic [DATA_W-1:0] dq_in, dq_out, mem_rd_data, mem_wr_data;
   logic [35:0] shadow [16];
   int fails = 0;
   int samples_checked = 0;
   pbsi_sram_if DUT (.core_clk, .rst, .addr, .proc_addr_strobe_n,
      .ctrl_addr_strobe_n, .burst_advance_n, .chip_select_first_n,
      .chip_select_second, .chip_select_third_n, .all_bytes_write_n,
      .byte_write_enable_n, .byte_lane_select_n, .output_enable_n,
      .sleep_request, .burst_order_strap, .dq_in, .dq_out,
      .parity_lines_in, .parity_lines_out, .dq_oe_n, .mem_rd_addr,
      .mem_rd_data, .mem_rd_parity, .mem_wr_en, .mem_byte_we,
      .mem_wr_addr, .mem_wr_data, .mem_wr_parity, .sleeping,
      .test_clk, .test_data_in, .test_mode_select,
      .test_data_out);
   pbsi_mem_model mem_model (.core_clk, .mem_rd_addr, .mem_rd_data,
      .mem_rd_parity, .mem_wr_en, .mem_byte_we, .mem_wr_addr,
      .mem_wr_data, .mem_wr_parity);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic expect_eq(input logic [35:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // values set here are taken by the design at the following edge
   task automatic drive(input logic c_n, p_n, s1_n, s2, g_n, b_n,
         input logic [3:0] l_n, input logic [ADDR_W-1:0] a);
      @(posedge core_clk);
      ctrl_addr_strobe_n <= c_n;
      proc_addr_strobe_n <= p_n;
      chip_select_first_n <= s1_n;
      chip_select_second <= s2;
      all_bytes_write_n <= g_n;
      byte_write_enable_n <= b_n;
      byte_lane_select_n <= l_n;
      addr <= a;
   endtask
   task automatic idle();
      drive(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, addr);
   endtask
   task automatic t_write(input logic [ADDR_W-1:0] a, input logic [35:0] v,
         input logic g_n, b_n, input logic [3:0] l_n);
      logic [3:0] we;
      int n;
      we = !g_n ? 4'hF : (b_n ? 4'h0 : ~l_n);
      drive(1'b0, 1'b1, 1'b0, 1'b1, g_n, b_n, l_n, a);
      {parity_lines_in, dq_in} <= v;
      output_enable_n <= 1'b1;
      idle();
      #1;
      n = 0;
      while (mem_wr_en !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      expect_eq(36'(mem_wr_en), 36'h1, "write pulse");
      expect_eq(36'(mem_byte_we), 36'(we), "lanes");
      expect_eq(36'(mem_wr_addr), 36'(a), "write addr");
      for (int l = 0; l < 4; l++) begin
         if (we[l]) begin
            shadow[a[3:0]][8*l +: 8] = v[8*l +: 8];
            shadow[a[3:0]][32+l] = v[32+l];
         end
      end
   endtask
   task automatic t_read_pair(input logic [ADDR_W-1:0] a, b);
      drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, a);
      output_enable_n <= 1'b0;
      drive(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, a);
      drive(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, b);
      #1;
      expect_eq(36'(mem_rd_addr), 36'(a), "read addr");
      expect_eq(36'(dq_oe_n), 36'h1, "first cycle masked");
      idle();
      #1;
      expect_eq({parity_lines_out, dq_out}, shadow[a[3:0]], "rd a");
      expect_eq(36'(dq_oe_n), 36'h0, "driving");
      idle();
      #1;
      expect_eq({parity_lines_out, dq_out}, shadow[b[3:0]], "rd b");
      @(posedge core_clk);
      output_enable_n <= 1'b1;
      #1;
      expect_eq(36'(dq_oe_n), 36'h1, "oe high");
      @(posedge core_clk);
      output_enable_n <= 1'b0;
      #1;
      expect_eq(36'(dq_oe_n), 36'h0, "oe low");
      drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, a);
      idle();
      #1;
      expect_eq(36'(dq_oe_n), 36'h1, "deselect");
   endtask
   task automatic t_burst(input logic strap, input logic [1:0] start);
      logic [ADDR_W-1:0] a;
      logic [1:0] e;
      a = {14'h0, 2'h1, start};
      @(posedge core_clk);
      burst_order_strap <= strap;
      // strap passes a two-flop synchroniser
      repeat (3) @(posedge core_clk);
      drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, a);
      idle();
      burst_advance_n <= 1'b0;
      #1;
      expect_eq(36'(mem_rd_addr), 36'(a), "burst load");
      for (int k = 1; k < 5; k++) begin
         @(posedge core_clk);
         #1;
         e = strap ? (start ^ 2'(k)) : (start + 2'(k));
         expect_eq(36'(mem_rd_addr), 36'({a[17:2], e}), "step");
      end
      @(posedge core_clk);
      burst_advance_n <= 1'b1;
   endtask
   task automatic t_priority();
      drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 18'h00005);
      idle();
      #1;
      expect_eq(36'(mem_rd_addr), 36'h5, "both strobes");
      repeat (3) begin
         @(posedge core_clk);
         #1;
         expect_eq(36'(mem_wr_en), 36'h0, "no ctrl write");
      end
      drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 18'h00009);
      idle();
      #1;
      expect_eq(36'(mem_rd_addr), 36'h5, "proc ignored");
      expect_eq({parity_lines_out, dq_out}, shadow[5], "pipe");
      expect_eq(36'(dq_oe_n), 36'h0, "still driving");
      drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 18'h00009);
      idle();
      #1;
      expect_eq(36'(dq_oe_n), 36'h1, "ctrl deselects");
   endtask
   task automatic t_sleep();
      @(posedge core_clk);
      sleep_request <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      expect_eq(36'(sleeping), 36'h1, "asleep");
      drive(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 18'h0000C);
      idle();
      repeat (3) begin
         @(posedge core_clk);
         #1;
         expect_eq(36'(mem_wr_en), 36'h0, "write while asleep");
      end
      @(posedge core_clk);
      sleep_request <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      expect_eq(36'(sleeping), 36'h0, "awake");
   endtask
   // test clock kept far below the core clock; bypass stage only
   task automatic t_scan();
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         test_data_in <= !k[0];
         repeat (8) @(posedge core_clk);
         test_clk <= 1'b1;
         repeat (8) @(posedge core_clk);
         #1;
         expect_eq(36'(test_data_out), 36'(k[0]), "scan held");
         @(posedge core_clk);
         test_clk <= 1'b0;
         repeat (8) @(posedge core_clk);
         #1;
         expect_eq(36'(test_data_out), 36'(!k[0]), "scan out");
      end
   endtask
   initial begin
      // long enough for every scenario with a wide margin
      repeat (3000) @(posedge core_clk);
      fails++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      {ctrl_addr_strobe_n, proc_addr_strobe_n, burst_advance_n} = 3'h7;
      {all_bytes_write_n, byte_write_enable_n, output_enable_n} = 3'h7;
      {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h2;
      {sleep_request, burst_order_strap} = 2'h1;
      {test_clk, test_data_in, test_mode_select} = 3'h0;
      byte_lane_select_n = 4'hF;
      addr = 18'h00000;
      dq_in = 32'h00000000;
      parity_lines_in = 4'h0;
      for (int i = 0; i < 16; i++) begin
         shadow[i] = {i[3:0], 32'hC3A50000 | i};
      end
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      t_write(18'h00003, 36'h511223344, 1'b0, 1'b1, 4'hF);
      t_write(18'h00003, 36'hAAABBCCDD, 1'b1, 1'b0, 4'hA);
      t_write(18'h00004, 36'h6DEADBEEF, 1'b0, 1'b0, 4'h5);
      t_read_pair(18'h00003, 18'h00004);
      t_read_pair(18'h00007, 18'h00003);
      for (int s = 0; s < 2; s++) begin
         for (int st = 0; st < 4; st++) begin
            t_burst(s[0], st[1:0]);
         end
      end
      t_priority();
      t_sleep();
      t_read_pair(18'h0000C, 18'h00004);
      t_scan();
      summarize();
   end
endmodule
